// ===== design/sr_event_group.sv
// Purpose: one condition/event/enable register group with its summary bit
// Assumes: condition inputs synchronous to clk
// Notes:   events latch on a rising condition; a set in the clear cycle wins
`timescale 1ns/100ps
module sr_event_group
  import sr_pkg::*;
#(
  parameter int WIDTH = 16,
  parameter logic [WIDTH-1:0] ONE_MASK = '0,
  parameter logic [WIDTH-1:0] LIVE_MASK = '1,
  parameter logic [WIDTH-1:0] MASK_RESET = '0
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // raw conditions and controls
  input wire logic [WIDTH-1:0] cond_in,
  input wire logic clear,
  input wire logic preset,
  input wire logic mask_wr,
  input wire logic [WIDTH-1:0] mask_data,
  // register views
  output logic [WIDTH-1:0] condition,
  output logic [WIDTH-1:0] event_latch,
  output logic [WIDTH-1:0] mask,
  output logic summary
);

  if (WIDTH < 1 || WIDTH > SR_DATA_W) begin : g_bad_width
    $error("sr_event_group: WIDTH out of range");
  end

  logic [WIDTH-1:0] cond_prev;
  logic [WIDTH-1:0] rise;

  // fixed bits are forced so they never depend on the raw input
  assign condition = (cond_in & LIVE_MASK) | ONE_MASK;
  assign rise = condition & ~cond_prev;

  // previous condition starts at the fixed ones so they never raise an event
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cond_prev <= ONE_MASK;
    end else begin
      cond_prev <= condition;
    end
  end

  // sticky event latch; a new edge in the clearing cycle survives
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      event_latch <= '0;
    end else begin
      event_latch <= (event_latch & ~{WIDTH{clear | preset}}) | rise;
    end
  end

  // enable mask, returned to default by preset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mask <= MASK_RESET;
    end else if (preset) begin
      mask <= MASK_RESET;
    end else if (mask_wr) begin
      mask <= mask_data;
    end
  end

  assign summary = |(event_latch & mask);

endmodule

// ===== design/sr_status.sv
// Purpose: status reporting register bank of a remote pressure instrument
// Assumes: commands arrive decoded from the command parser, one per cycle at most
// Notes:   reads answer one cycle after the command; writes give no answer
`timescale 1ns/100ps
module sr_status
  import sr_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // host command port
  input wire sr_req_t req,
  output sr_rsp_t rsp,
  // instrument state feeding the operation group
  input wire sr_oper_in_t oper_in,
  // instrument state feeding the questionable group
  input wire sr_ques_in_t ques_in,
  // parser and output queue events
  input wire sr_dev_evt_t dev_evt,
  // status outputs
  output logic [7:0] status_byte,
  output logic service_request
);

  // ---------------------------------------------------------------
  // command decode
  // ---------------------------------------------------------------
  logic rd_summary;
  logic wr_srq_mask;
  logic rd_srq_mask;
  logic rd_std_latch;
  logic wr_std_mask;
  logic rd_std_mask;
  logic clear_status;
  logic op_complete;
  logic rd_operation_event_latch;
  logic rd_oper_cond;
  logic wr_oper_mask;
  logic rd_oper_mask;
  logic rd_questionable_event_latch;
  logic rd_ques_cond;
  logic wr_ques_mask;
  logic rd_ques_mask;
  logic preset;
  logic is_read;

  // one strobe per command; unknown codes decode to nothing
  always_comb begin
    rd_summary = 1'b0;
    wr_srq_mask = 1'b0;
    rd_srq_mask = 1'b0;
    rd_std_latch = 1'b0;
    wr_std_mask = 1'b0;
    rd_std_mask = 1'b0;
    clear_status = 1'b0;
    op_complete = 1'b0;
    rd_operation_event_latch = 1'b0;
    rd_oper_cond = 1'b0;
    wr_oper_mask = 1'b0;
    rd_oper_mask = 1'b0;
    rd_questionable_event_latch = 1'b0;
    rd_ques_cond = 1'b0;
    wr_ques_mask = 1'b0;
    rd_ques_mask = 1'b0;
    preset = 1'b0;
    if (req.valid) begin
      unique case (req.cmd)
        SR_CMD_RD_SUMMARY: rd_summary = 1'b1;
        SR_CMD_WR_SRQ_MASK: wr_srq_mask = 1'b1;
        SR_CMD_RD_SRQ_MASK: rd_srq_mask = 1'b1;
        SR_CMD_RD_STD_LATCH: rd_std_latch = 1'b1;
        SR_CMD_WR_STD_MASK: wr_std_mask = 1'b1;
        SR_CMD_RD_STD_MASK: rd_std_mask = 1'b1;
        SR_CMD_CLEAR_STATUS: clear_status = 1'b1;
        SR_CMD_OP_COMPLETE: op_complete = 1'b1;
        SR_CMD_RD_OPERATION_EVENT_LATCH: rd_operation_event_latch = 1'b1;
        SR_CMD_RD_OPER_COND: rd_oper_cond = 1'b1;
        SR_CMD_WR_OPER_MASK: wr_oper_mask = 1'b1;
        SR_CMD_RD_OPER_MASK: rd_oper_mask = 1'b1;
        SR_CMD_RD_QUESTIONABLE_EVENT_LATCH: rd_questionable_event_latch = 1'b1;
        SR_CMD_RD_QUES_COND: rd_ques_cond = 1'b1;
        SR_CMD_WR_QUES_MASK: wr_ques_mask = 1'b1;
        SR_CMD_RD_QUES_MASK: rd_ques_mask = 1'b1;
        SR_CMD_PRESET: preset = 1'b1;
        default: ;  // codes 17 to 31 of the 5-bit field name no command
      endcase
    end
  end

  assign is_read = rd_summary | rd_srq_mask | rd_std_latch | rd_std_mask |
                   rd_operation_event_latch | rd_oper_cond | rd_oper_mask |
                   rd_questionable_event_latch | rd_ques_cond | rd_ques_mask;

  // ---------------------------------------------------------------
  // operation group
  // ---------------------------------------------------------------
  logic [15:0] oper_raw;
  logic [15:0] operation_condition;
  logic [15:0] operation_event_latch;
  logic [15:0] operation_event_mask;
  logic oper_summary;

  // live condition bits; fixed ones and zeros are forced inside the group
  always_comb begin
    oper_raw = 16'h0000;
    oper_raw[OP_CALIB] = oper_in.calibrating;
    oper_raw[OP_SETTLE] = oper_in.settling;
    oper_raw[OP_RANGING] = oper_in.ranging;
    oper_raw[OP_SELF_TEST] = oper_in.self_test;
    oper_raw[OP_PROGRAM] = oper_in.program_running;
  end

  // measuring reads one, unused bits read zero
  sr_event_group #(
    .WIDTH(SR_DATA_W),
    .ONE_MASK(OP_ONE_MASK),
    .LIVE_MASK(OP_LIVE_MASK),
    .MASK_RESET(GRP_MASK_RESET)
  ) u_oper (
    .clk(clk),
    .rst_n(rst_n),
    .cond_in(oper_raw),
    .clear(rd_operation_event_latch | clear_status),
    .preset(preset),
    .mask_wr(wr_oper_mask),
    .mask_data(req.data),
    .condition(operation_condition),
    .event_latch(operation_event_latch),
    .mask(operation_event_mask),
    .summary(oper_summary)
  );

  // ---------------------------------------------------------------
  // questionable group
  // ---------------------------------------------------------------
  logic [15:0] ques_raw;
  logic [15:0] questionable_condition;
  logic [15:0] questionable_event_latch;
  logic [15:0] questionable_event_mask;
  logic ques_summary;

  // a command warning is a pulse, so its rising edge latches the event
  always_comb begin
    ques_raw = 16'h0000;
    ques_raw[QU_VOLTAGE] = ques_in.supply_off;
    ques_raw[QU_CLOCK] = ques_in.clock_unset;
    ques_raw[QU_OVEN] = ques_in.oven_off;
    ques_raw[QU_CALIB] = ques_in.uncalibrated;
    ques_raw[QU_OVERRANGE] = ques_in.over_range;
    ques_raw[QU_CMD_WARN] = ques_in.param_ignored;
  end

  // unused questionable bits are masked off by the live mask
  sr_event_group #(
    .WIDTH(SR_DATA_W),
    .ONE_MASK(QU_ONE_MASK),
    .LIVE_MASK(QU_LIVE_MASK),
    .MASK_RESET(GRP_MASK_RESET)
  ) u_ques (
    .clk(clk),
    .rst_n(rst_n),
    .cond_in(ques_raw),
    .clear(rd_questionable_event_latch | clear_status),
    .preset(preset),
    .mask_wr(wr_ques_mask),
    .mask_data(req.data),
    .condition(questionable_condition),
    .event_latch(questionable_event_latch),
    .mask(questionable_event_mask),
    .summary(ques_summary)
  );

  // ---------------------------------------------------------------
  // standard event latch
  // ---------------------------------------------------------------
  logic [7:0] std_set;
  logic [7:0] standard_event_latch;
  logic [7:0] standard_event_mask;
  logic standard_event_summary;

  // power-on comes from the reset value, not from a set pulse
  always_comb begin
    std_set = 8'h00;
    std_set[SE_CMD_ERR] = dev_evt.syntax_err;
    std_set[SE_EXEC_ERR] = dev_evt.exec_err;
    std_set[SE_DEV_ERR] = dev_evt.device_err;
    std_set[SE_QUERY_ERR] = dev_evt.query_req & ~dev_evt.response_ready;
    std_set[SE_OP_COMPLETE] = op_complete;
  end

  sr_std_event #(
    .WIDTH(SR_BYTE_W),
    .RESET_VAL(SE_RESET),
    .ZERO_MASK(SE_ZERO_MASK)
  ) u_std (
    .clk(clk),
    .rst_n(rst_n),
    .set_in(std_set),
    .clear(rd_std_latch | clear_status),
    .mask_wr(wr_std_mask),
    .mask_data(req.data[7:0]),
    .latch(standard_event_latch),
    .mask(standard_event_mask),
    .summary(standard_event_summary)
  );

  // ---------------------------------------------------------------
  // status summary byte and service request
  // ---------------------------------------------------------------
  logic [7:0] status_summary_byte;
  logic [7:0] service_request_mask;
  logic message_available;

  assign message_available = dev_evt.response_ready;

  // bits 6, 1 and 0 are never driven and stay zero
  always_comb begin
    status_summary_byte = 8'h00;
    status_summary_byte[SB_OPER_SUM] = oper_summary;
    status_summary_byte[SB_STD_SUM] = standard_event_summary;
    status_summary_byte[SB_MSG_AVAIL] = message_available;
    status_summary_byte[SB_QUES_SUM] = ques_summary;
    status_summary_byte[SB_ERRQ] = dev_evt.error_queue_nonempty;
  end

  // service request mask, written only by the host
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      service_request_mask <= SB_MASK_RESET;
    end else if (wr_srq_mask) begin
      service_request_mask <= req.data[7:0];
    end
  end

  // registered copies so the pins never glitch with the inputs
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      status_byte <= 8'h00;
      service_request <= 1'b0;
    end else begin
      status_byte <= status_summary_byte;
      service_request <= |(status_summary_byte & service_request_mask);
    end
  end

  // ---------------------------------------------------------------
  // read answer
  // ---------------------------------------------------------------
  logic [15:0] next_rdata;

  // reads of event latches capture the value before the clear lands
  always_comb begin
    next_rdata = 16'h0000;
    if (rd_summary) begin
      next_rdata = {8'h00, status_summary_byte};
    end else if (rd_srq_mask) begin
      next_rdata = {8'h00, service_request_mask};
    end else if (rd_std_latch) begin
      next_rdata = {8'h00, standard_event_latch};
    end else if (rd_std_mask) begin
      next_rdata = {8'h00, standard_event_mask};
    end else if (rd_operation_event_latch) begin
      next_rdata = operation_event_latch;
    end else if (rd_oper_cond) begin
      next_rdata = operation_condition;
    end else if (rd_oper_mask) begin
      next_rdata = operation_event_mask;
    end else if (rd_questionable_event_latch) begin
      next_rdata = questionable_event_latch;
    end else if (rd_ques_cond) begin
      next_rdata = questionable_condition;
    end else if (rd_ques_mask) begin
      next_rdata = questionable_event_mask;
    end
  end

  // answer valid for exactly one cycle after a read command
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rsp <= '0;
    end else begin
      rsp.valid <= is_read;
      rsp.data <= next_rdata;
    end
  end

endmodule

// ===== design/sr_std_event.sv
// Purpose: standard event latch with its enable mask and summary bit
// Assumes: set inputs are one-cycle pulses
// Notes:   reset value carries the power-on event
`timescale 1ns/100ps
module sr_std_event
  import sr_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter logic [WIDTH-1:0] RESET_VAL = '0,
  parameter logic [WIDTH-1:0] ZERO_MASK = '0
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // events and controls
  input wire logic [WIDTH-1:0] set_in,
  input wire logic clear,
  input wire logic mask_wr,
  input wire logic [WIDTH-1:0] mask_data,
  // register views
  output logic [WIDTH-1:0] latch,
  output logic [WIDTH-1:0] mask,
  output logic summary
);

  if (WIDTH < 1 || WIDTH > SR_BYTE_W) begin : g_bad_width
    $error("sr_std_event: WIDTH out of range");
  end

  // sticky bits; set beats clear, forced-zero bits never latch
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      latch <= RESET_VAL;
    end else begin
      latch <= ((latch & ~{WIDTH{clear}}) | set_in) & ~ZERO_MASK;
    end
  end

  // enable mask
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mask <= WIDTH'(SE_MASK_RESET);
    end else if (mask_wr) begin
      mask <= mask_data;
    end
  end

  assign summary = |(latch & mask);

endmodule

// ===== shared/sr_pkg.sv
// Purpose: shared constants, commands and carriers of the status reporting block
// Assumes: one system clock, registers reached only through the command port
// Notes:   bit positions, masks and reset values live here and nowhere else
package sr_pkg;

  // ---------------------------------------------------------------
  // widths
  // ---------------------------------------------------------------
  localparam int SR_DATA_W = 16;
  localparam int SR_BYTE_W = 8;

  // ---------------------------------------------------------------
  // status summary byte bit positions
  // ---------------------------------------------------------------
  localparam int SB_OPER_SUM = 7;
  localparam int SB_STD_SUM = 5;
  localparam int SB_MSG_AVAIL = 4;
  localparam int SB_QUES_SUM = 3;
  localparam int SB_ERRQ = 2;

  // ---------------------------------------------------------------
  // standard event latch bit positions and masks
  // ---------------------------------------------------------------
  localparam int SE_POWER_ON = 7;
  localparam int SE_CMD_ERR = 5;
  localparam int SE_EXEC_ERR = 4;
  localparam int SE_DEV_ERR = 3;
  localparam int SE_QUERY_ERR = 2;
  localparam int SE_OP_COMPLETE = 0;
  localparam logic [7:0] SE_ZERO_MASK = 8'h42;
  localparam logic [7:0] SE_RESET = 8'h80;
  localparam logic [7:0] SB_MASK_RESET = 8'h00;
  localparam logic [7:0] SE_MASK_RESET = 8'h00;

  // ---------------------------------------------------------------
  // operation group bit positions and masks
  // ---------------------------------------------------------------
  localparam int OP_CALIB = 0;
  localparam int OP_SETTLE = 1;
  localparam int OP_RANGING = 2;
  localparam int OP_SELF_TEST = 8;
  localparam int OP_PROGRAM = 14;
  localparam logic [15:0] OP_ONE_MASK = 16'h0010;
  localparam logic [15:0] OP_LIVE_MASK = 16'h4107;

  // ---------------------------------------------------------------
  // questionable group bit positions and masks
  // ---------------------------------------------------------------
  localparam int QU_VOLTAGE = 0;
  localparam int QU_CLOCK = 2;
  localparam int QU_OVEN = 3;
  localparam int QU_CALIB = 7;
  localparam int QU_OVERRANGE = 8;
  localparam int QU_CMD_WARN = 14;
  localparam logic [15:0] QU_ONE_MASK = 16'h0000;
  localparam logic [15:0] QU_LIVE_MASK = 16'h418D;
  localparam logic [15:0] GRP_MASK_RESET = 16'h0000;

  // ---------------------------------------------------------------
  // host commands
  // ---------------------------------------------------------------
  typedef enum logic [4:0] {
    SR_CMD_RD_SUMMARY,
    SR_CMD_WR_SRQ_MASK,
    SR_CMD_RD_SRQ_MASK,
    SR_CMD_RD_STD_LATCH,
    SR_CMD_WR_STD_MASK,
    SR_CMD_RD_STD_MASK,
    SR_CMD_CLEAR_STATUS,
    SR_CMD_OP_COMPLETE,
    SR_CMD_RD_OPERATION_EVENT_LATCH,
    SR_CMD_RD_OPER_COND,
    SR_CMD_WR_OPER_MASK,
    SR_CMD_RD_OPER_MASK,
    SR_CMD_RD_QUESTIONABLE_EVENT_LATCH,
    SR_CMD_RD_QUES_COND,
    SR_CMD_WR_QUES_MASK,
    SR_CMD_RD_QUES_MASK,
    SR_CMD_PRESET
  } sr_cmd_t;

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic valid;
    sr_cmd_t cmd;
    logic [15:0] data;
  } sr_req_t;

  typedef struct packed {
    logic valid;
    logic [15:0] data;
  } sr_rsp_t;

  typedef struct packed {
    logic calibrating;
    logic settling;
    logic ranging;
    logic self_test;
    logic program_running;
  } sr_oper_in_t;

  typedef struct packed {
    logic supply_off;
    logic clock_unset;
    logic oven_off;
    logic uncalibrated;
    logic over_range;
    logic param_ignored;
  } sr_ques_in_t;

  typedef struct packed {
    logic syntax_err;
    logic exec_err;
    logic device_err;
    logic query_req;
    logic response_ready;
    logic error_queue_nonempty;
  } sr_dev_evt_t;

endpackage

// ===== sim/sr_host_model.sv
// Purpose: remote host issuing decoded status commands
// Assumes: one command in flight, answer one cycle after taking
// Notes:   idle data is inverted so a stale value never looks live
`timescale 1ns/100ps
module sr_host_model
  import sr_pkg::*;
(
  // clock
  input wire logic clk,
  // command port
  output sr_req_t req,
  input wire sr_rsp_t rsp
);
  initial req = '0;
  // one command; ok tells whether an answer came within the bound
  task automatic xfer(input sr_cmd_t cmd, input logic [15:0] d, output logic [15:0] got, output logic ok);
    int i;
    got = 16'h0000;
    ok = 1'b0;
    @(posedge clk);
    req <= '{valid: 1'b1, cmd: cmd, data: d}; // masks are the host's to choose
    @(posedge clk);
    req <= '{valid: 1'b0, cmd: cmd, data: ~d};
    for (i = 0; i < 3 && !ok; i++) begin
      #1;
      if (rsp.valid === 1'b1) begin
        got = rsp.data;
        ok = 1'b1;
      end else begin
        @(posedge clk);
      end
    end
  endtask
endmodule

// ===== sim/sr_status_monitor.sv
// Purpose: port checks on the status block
// Assumes: one clock, async active-low reset
// Notes:   masks are internal, so fixed bits are checked on read answers
`timescale 1ns/100ps
module sr_status_monitor
  import sr_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // command port
  input wire sr_req_t req,
  input wire sr_rsp_t rsp,
  // status inputs
  input wire sr_oper_in_t oper_in,
  input wire sr_ques_in_t ques_in,
  input wire sr_dev_evt_t dev_evt,
  // status outputs
  input wire logic [7:0] status_byte,
  input wire logic service_request
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic rd_cmd;
  // only known read codes answer; writes and unknown codes stay silent
  assign rd_cmd = req.valid && req.cmd <= SR_CMD_PRESET && !(req.cmd inside {SR_CMD_WR_SRQ_MASK,
    SR_CMD_WR_STD_MASK, SR_CMD_CLEAR_STATUS, SR_CMD_OP_COMPLETE, SR_CMD_WR_OPER_MASK, SR_CMD_WR_QUES_MASK,
    SR_CMD_PRESET});
  a_read_answers: assert property (rd_cmd |=> rsp.valid) else $error("read gave no answer");
  a_no_stray_answer: assert property (!rd_cmd |=> !rsp.valid) else $error("answer without a read");
  a_low_bits_zero: assert property (status_byte[1:0] == 2'h0) else $error("summary low bits set");
  a_msg_avail: assert property ($past(rst_n) |-> status_byte[SB_MSG_AVAIL] == $past(dev_evt.response_ready))
    else $error("message available bit wrong");
  a_errq_bit: assert property ($past(rst_n) |-> status_byte[SB_ERRQ] == $past(dev_evt.error_queue_nonempty))
    else $error("error queue bit wrong");
  a_srq_cause: assert property (service_request |-> status_byte != 8'h00) else $error("service request uncaused");
  a_oper_fixed: assert property (req.valid && req.cmd == SR_CMD_RD_OPER_COND |=>
    (rsp.data & ~OP_LIVE_MASK) == OP_ONE_MASK) else $error("operation fixed bits wrong");
  a_ques_fixed: assert property (req.valid && req.cmd inside {SR_CMD_RD_QUESTIONABLE_EVENT_LATCH, SR_CMD_RD_QUES_COND} |=>
    (rsp.data & ~QU_LIVE_MASK) == 16'h0000) else $error("questionable fixed bits wrong");
  a_std_fixed: assert property (req.valid && req.cmd == SR_CMD_RD_STD_LATCH |=>
    (rsp.data & {8'hFF, SE_ZERO_MASK}) == 16'h0000) else $error("standard event fixed bits wrong");
  // main scenarios reached
  c_answer: cover property (rsp.valid);
  c_srq: cover property (service_request);
  c_group_sums: cover property (status_byte[SB_OPER_SUM] || status_byte[SB_QUES_SUM]);
endmodule

bind sr_status sr_status_monitor u_mon (.clk(clk), .rst_n(rst_n), .req(req), .rsp(rsp), .oper_in(oper_in),
  .ques_in(ques_in), .dev_evt(dev_evt), .status_byte(status_byte), .service_request(service_request));

// ===== sim/tb_top.sv
// Purpose: command-level test of the status block
// Assumes: host model drives the command port
// Notes:   expected words built from the documented bit positions
`timescale 1ns/100ps
module tb_top
  import sr_pkg::*;
;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  sr_req_t req;
  sr_rsp_t rsp;
  sr_oper_in_t oper_in = '0;
  sr_ques_in_t ques_in = '0;
  sr_dev_evt_t dev_evt = '0;
  logic [7:0] status_byte;
  logic service_request;
  int miscompares = 0;
  int n_checks = 0;
  logic [15:0] got;
  logic ok;

  always #50 clk = ~clk;

  sr_status DUT (.clk(clk), .rst_n(rst_n), .req(req), .rsp(rsp), .oper_in(oper_in), .ques_in(ques_in),
    .dev_evt(dev_evt), .status_byte(status_byte), .service_request(service_request));
  sr_host_model host (.clk(clk), .req(req), .rsp(rsp));

  // -----
  // helpers
  // -----
  task automatic chk(input logic [15:0] seen, input logic [15:0] want);
    n_checks++;
    if (seen !== want) begin
      miscompares++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask

  task automatic print_verdict;
    $display("checks %0d, mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // a missing answer ends the run at once
  task automatic rd(input sr_cmd_t cmd, input logic [15:0] want);
    host.xfer(cmd, 16'h0000, got, ok);
    chk({15'h0000, ok}, 16'h0001);
    if (ok !== 1'b1) print_verdict();
    chk(got, want);
  endtask

  task automatic wr(input sr_cmd_t cmd, input logic [15:0] d);
    host.xfer(cmd, d, got, ok);
    chk({15'h0000, ok}, 16'h0000);
  endtask

  // status byte lags its cause by up to two edges
  task automatic settle;
    repeat (3) @(posedge clk);
    #1;
  endtask

  // -----
  // sequence
  // -----
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    rd(SR_CMD_RD_STD_LATCH, 16'h0080);
    rd(SR_CMD_RD_STD_LATCH, 16'h0000);
    // all standard error sources at once, then operation complete; query while no response is ready
    wr(SR_CMD_WR_STD_MASK, 16'h00FF);
    @(posedge clk);
    dev_evt <= 6'b111100;
    @(posedge clk);
    dev_evt <= '0;
    wr(SR_CMD_OP_COMPLETE, 16'h0000);
    settle();
    chk({8'h00, status_byte}, 16'h0020);
    wr(SR_CMD_WR_SRQ_MASK, 16'h0020);
    settle();
    chk({15'h0000, service_request}, 16'h0001);
    rd(SR_CMD_RD_SRQ_MASK, 16'h0020);
    rd(SR_CMD_RD_STD_LATCH, 16'h003D);
    settle();
    chk({15'h0000, service_request}, 16'h0000);
    // clear status wipes a pending device error
    @(posedge clk);
    dev_evt <= 6'b001000;
    @(posedge clk);
    dev_evt <= '0;
    wr(SR_CMD_CLEAR_STATUS, 16'h0000);
    rd(SR_CMD_RD_STD_LATCH, 16'h0000);
    // queue levels feed the summary directly
    @(posedge clk);
    dev_evt <= 6'b000011;
    settle();
    chk({8'h00, status_byte}, 16'h0014);
    @(posedge clk);
    dev_evt <= '0;
    // operation group: only the settling event enabled
    @(posedge clk);
    oper_in <= '1;
    settle();
    rd(SR_CMD_RD_OPER_COND, 16'h4117);
    wr(SR_CMD_WR_OPER_MASK, 16'h0002);
    settle();
    chk({8'h00, status_byte}, 16'h0080);
    rd(SR_CMD_RD_OPER_MASK, 16'h0002);
    rd(SR_CMD_RD_OPERATION_EVENT_LATCH, 16'h4107);
    rd(SR_CMD_RD_OPERATION_EVENT_LATCH, 16'h0000);
    settle();
    chk({8'h00, status_byte}, 16'h0000);
    // questionable group; the warning is a one-cycle pulse
    @(posedge clk);
    ques_in <= 6'b111111;
    @(posedge clk);
    ques_in <= 6'b111110;
    settle();
    rd(SR_CMD_RD_QUES_COND, 16'h018D);
    wr(SR_CMD_WR_QUES_MASK, 16'h4000);
    settle();
    chk({8'h00, status_byte}, 16'h0008);
    rd(SR_CMD_RD_QUESTIONABLE_EVENT_LATCH, 16'h418D);
    rd(SR_CMD_RD_QUESTIONABLE_EVENT_LATCH, 16'h0000);
    // preset drops the group masks
    wr(SR_CMD_WR_OPER_MASK, 16'hFFFF);
    wr(SR_CMD_PRESET, 16'h0000);
    rd(SR_CMD_RD_QUES_MASK, 16'h0000);
    rd(SR_CMD_RD_OPER_MASK, 16'h0000);
    // an unknown code gets no answer and changes nothing
    wr(sr_cmd_t'(5'h1F), 16'hFFFF);
    rd(SR_CMD_RD_SUMMARY, 16'h0000);
    // a stray code must not land as a mask write
    rd(SR_CMD_RD_SRQ_MASK, 16'h0020);
    rd(SR_CMD_RD_OPER_MASK, 16'h0000);
    rd(SR_CMD_RD_STD_MASK, 16'h00FF);
    print_verdict();
  end
endmodule
